// *** hw/codec_defaults.sv ***
// default-state sequencer and byte-level block access to the tone RAM
// assumes the host port delivers whole bytes synchronous to ref_clk
`include "codec_defaults_map.svh"
module codec_defaults #(
  parameter int RST_PIN_CYCLES = `RST_PIN_CYCLES,
  parameter logic [7:0] ID_BYTE = `ID_BYTE_DEFAULT // arbitrary value
) (
  // clock and reset
  input  wire logic                     ref_clk,
  input  wire logic                     rstn,
  // reset sources
  input  wire logic                     reset_pin_n,
  input  wire logic                     reset_cmd,
  // host byte port
  input  wire logic                     cs_n,
  input  wire logic                     rx_valid,
  input  wire logic [7:0]               rx_byte,
  input  wire logic                     tx_ready,
  output      logic                     tx_valid,
  output      logic [7:0]               tx_byte,
  output      logic                     busy,
  // default-state outputs
  output      logic                     in_default,
  output      codec_defaults_pkg::codec_cfg_s  cfg,
  output      codec_defaults_pkg::codec_feat_s feat
);
  logic        rst_meta;
  logic        rst_sync_n;
  logic [$clog2(RST_PIN_CYCLES+1)-1:0] low_cnt;
  logic        pin_reset;
  logic        apply_default;

  codec_defaults_pkg::xfer_e state;
  codec_defaults_pkg::xfer_e next_state;
  logic [1:0]  blk;
  logic [2:0]  word;
  logic [7:0]  hi_hold;
  logic        ram_wr;
  logic [15:0] ram_rd;
  logic        last_word;
  logic        cmd_hit;
  logic        cmd_write;
  logic        tx_take;
  logic        byte_in;
  logic        load_default;
  logic        in_idle;
  logic        in_wr_hi;
  logic        in_wr_lo;
  logic        in_rd_id;
  logic        in_rd_hi;
  logic        in_rd_lo;
  logic        word_step;
  logic        rd_settle;
  logic        offer_now;
  logic [7:0]  offer_byte;

  // two-flop release of the async reset
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      rst_meta   <= 1'b0;
      rst_sync_n <= 1'b0;
    end else begin
      rst_meta   <= 1'b1;
      rst_sync_n <= rst_meta;
    end
  end

  // reset pin must stay low for the full qualifying time
  always_ff @(posedge ref_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      low_cnt <= '0;
    end else if (reset_pin_n) begin
      low_cnt <= '0;
    end else if (!pin_reset) begin
      low_cnt <= low_cnt + 1'b1;
    end
  end

  assign pin_reset = (low_cnt >= ($clog2(RST_PIN_CYCLES+1))'(RST_PIN_CYCLES));
  assign apply_default = pin_reset || reset_cmd;

  function automatic codec_defaults_pkg::codec_cfg_s default_cfg();
    codec_defaults_pkg::codec_cfg_s c;
    c = '0;
    c.chan_power_up  = 4'h0;
    c.loopback_en    = 5'h00;
    c.cutoff_en      = 1'b0;
    c.tx_highway_sel = 4'h0;
    c.rx_highway_sel = 4'h0;
    c.mclk_sel       = `MCLK_SEL_DEFAULT;
    c.tx_slot_ch1    = 7'h00;
    c.tx_slot_ch2    = 7'h01;
    c.tx_slot_ch3    = 7'h02;
    c.tx_slot_ch4    = 7'h03;
    c.clock_slope    = 3'h0;
    c.mu_law         = 1'b0;
    c.filter_sel     = `FILTER_SEL_DEFAULT;
    return c;
  endfunction : default_cfg

  function automatic codec_defaults_pkg::codec_feat_s default_feat();
    codec_defaults_pkg::codec_feat_s f;
    f = '0;
    f.slic_bidir_pin_a_oe   = 4'h0;
    f.slic_bidir_pin_b_oe   = 4'h0;
    f.slic_bidir_pin_c_oe   = 4'h0;
    f.slic_input_a_debounce = 4'h0;
    f.slic_input_b_debounce = 4'h0;
    f.irq_mask_n            = 5'h00;
    f.irq_pending           = 1'b0;
    f.fsk_en                = 1'b0;
    f.tone_en               = 4'h0;
    f.ring_trip_en          = 1'b0;
    f.level_meter_en        = 1'b0;
    f.chopper_out_a         = 1'b1;
    f.chopper_out_b         = 1'b1;
    return f;
  endfunction : default_feat

  // read states offer a byte to the host
  function automatic logic is_read_state(codec_defaults_pkg::xfer_e s);
    logic r;
    r = 1'b0;
    case (s)
      codec_defaults_pkg::st_rd_id: r = 1'b1;
      codec_defaults_pkg::st_rd_hi: r = 1'b1;
      codec_defaults_pkg::st_rd_lo: r = 1'b1;
      default:                      r = 1'b0;
    endcase
    return r;
  endfunction : is_read_state

  // power-on and later resets all load the same default image
  assign load_default = apply_default || !in_default;

  always_ff @(posedge ref_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      cfg <= '0;
    end else if (load_default) begin
      cfg <= default_cfg();
    end
  end

  always_ff @(posedge ref_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      feat       <= '0;
      in_default <= 1'b0;
    end else if (load_default) begin
      feat       <= default_feat();
      in_default <= 1'b1;
    end
  end

  // command decode: b6..4 set, b3 clear, block in b1..0, bit 7 direction
  assign cmd_hit   = ((rx_byte & `CMD_TYPE_MASK) == `CMD_TYPE_VALUE);
  assign cmd_write = rx_byte[`CMD_DIR_BIT];
  assign last_word = (word == 3'h0);
  assign tx_take   = tx_valid && tx_ready;
  assign byte_in   = rx_valid && !cs_n && !apply_default;
  assign ram_wr    = in_wr_lo && byte_in;
  assign word_step = ram_wr || (in_rd_lo && tx_take);

  // one-hot views of the transfer state
  assign in_idle   = (state == codec_defaults_pkg::st_idle);
  assign in_wr_hi  = (state == codec_defaults_pkg::st_wr_hi);
  assign in_wr_lo  = (state == codec_defaults_pkg::st_wr_lo);
  assign in_rd_id  = (state == codec_defaults_pkg::st_rd_id);
  assign in_rd_hi  = (state == codec_defaults_pkg::st_rd_hi);
  assign in_rd_lo  = (state == codec_defaults_pkg::st_rd_lo);

  // a byte is offered only after the RAM read has followed the pointer
  assign offer_now = is_read_state(state) && !cs_n && !apply_default &&
                     !tx_take && !rd_settle;
  assign offer_byte = in_rd_id ? ID_BYTE :
                      in_rd_hi ? ram_rd[15:8] : ram_rd[7:0];

  // transfer sequencing; deselect or default load wins in the register
  always_comb begin
    next_state = state;
    case (state)
      codec_defaults_pkg::st_idle: begin
        if (byte_in && cmd_hit) begin
          next_state = cmd_write ? codec_defaults_pkg::st_wr_hi
                                 : codec_defaults_pkg::st_rd_id;
        end
      end
      codec_defaults_pkg::st_wr_hi: begin
        if (byte_in) begin
          next_state = codec_defaults_pkg::st_wr_lo;
        end
      end
      codec_defaults_pkg::st_wr_lo: begin
        if (byte_in) begin
          next_state = last_word ? codec_defaults_pkg::st_idle
                                 : codec_defaults_pkg::st_wr_hi;
        end
      end
      codec_defaults_pkg::st_rd_id: begin
        if (tx_take) begin
          next_state = codec_defaults_pkg::st_rd_hi;
        end
      end
      codec_defaults_pkg::st_rd_hi: begin
        if (tx_take) begin
          next_state = codec_defaults_pkg::st_rd_lo;
        end
      end
      codec_defaults_pkg::st_rd_lo: begin
        if (tx_take) begin
          next_state = last_word ? codec_defaults_pkg::st_idle
                                 : codec_defaults_pkg::st_rd_hi;
        end
      end
      default: next_state = codec_defaults_pkg::st_idle;
    endcase
  end

  // chip select high aborts; completed words stay written
  always_ff @(posedge ref_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      state <= codec_defaults_pkg::st_idle;
    end else if (cs_n || apply_default) begin
      state <= codec_defaults_pkg::st_idle;
    end else begin
      state <= next_state;
    end
  end

  // block latched with the command
  always_ff @(posedge ref_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      blk <= 2'h0;
    end else if (in_idle) begin
      blk <= rx_byte[1:0];
    end
  end

  // word pointer counts down from the top word of the block
  always_ff @(posedge ref_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      word <= `TOP_WORD;
    end else if (in_idle) begin
      word <= `TOP_WORD;
    end else if (word_step) begin
      word <= word - 3'h1;
    end
  end

  // high byte waits for its low byte
  always_ff @(posedge ref_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      hi_hold <= 8'h00;
    end else if (in_wr_hi && byte_in) begin
      hi_hold <= rx_byte;
    end
  end

  fsk_ram #(
    .AW (5),
    .DW (16)
  ) u_ram (
    .ref_clk (ref_clk),
    .wr_en   (ram_wr),
    .addr    ({blk, word}),
    .wr_data ({hi_hold, rx_byte}),
    .rd_data (ram_rd)
  );

  // a take leaves one cycle for the RAM read to follow the new word
  always_ff @(posedge ref_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      rd_settle <= 1'b0;
    end else begin
      rd_settle <= tx_take;
    end
  end

  // offer drops for the take cycle and the settle cycle
  always_ff @(posedge ref_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      tx_valid <= 1'b0;
    end else begin
      tx_valid <= offer_now;
    end
  end

  // byte held while offered, so it stands until taken
  always_ff @(posedge ref_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      tx_byte <= 8'h00;
    end else if (offer_now) begin
      tx_byte <= offer_byte;
    end
  end

  // a default load ends the transfer at once
  always_ff @(posedge ref_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      busy <= 1'b0;
    end else begin
      busy <= (next_state != codec_defaults_pkg::st_idle) && !cs_n &&
              !apply_default;
    end
  end
endmodule : codec_defaults

// *** hw/codec_defaults_map.svh ***
// constants for the codec default-state and shared tone-RAM access block
// assumes an 8 ns master clock and a byte-level host command port
// Operation
// - data moves high byte then low byte, word 7 down to word 0
// - read answers identification byte then sixteen block bytes
// - default state on power-on, reset command, or reset pin low 50 us
// - default: all four channels powered down in standby
// - default: all loopbacks and cutoff disabled
// - default: every channel uses highway one for transmit and receive
// - default: master clock selection is 2.048 MHz
// - default: slots 0 to 3 per channel, rate equals bit clock
// - default: A-law companding
// - default: programmable filters bypassed, high-pass filters enabled
// - default: all three bidirectional signaling pins are inputs
// - default: signaling inputs pass without debounce
// - default: interrupts masked and pending interrupts cleared
// - default: tone, FSK, ring trip and level meter disabled
// - default: both chopper outputs driven high
// - no reset alters RAM contents
// - RAM is four blocks of eight 16-bit words; command b4=1, b3=0
`ifndef CODEC_DEFAULTS_MAP_SVH
`define CODEC_DEFAULTS_MAP_SVH
`define CMD_DIR_BIT      7
`define CMD_B4_BIT       4
`define CMD_B3_BIT       3
`define CMD_BLK_MSB      2
`define CMD_TYPE_MASK    8'h78
`define CMD_TYPE_VALUE   8'h70
`define ID_BYTE_DEFAULT  8'h5A
`define CLK_PERIOD_NS    8
`define RST_PIN_MIN_US   50
`define RST_PIN_CYCLES   ((`RST_PIN_MIN_US * 1000 + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define MCLK_SEL_DEFAULT 4'h2
`define FILTER_SEL_DEFAULT 8'h08
`define TOP_WORD         3'h7
`endif

// *** hw/codec_defaults_pkg.sv ***
// types for the codec default-state block
// assumes codec_defaults_map.svh supplies the numbers
package codec_defaults_pkg;
  typedef enum logic [2:0] {
    st_idle, st_wr_hi, st_wr_lo, st_rd_id, st_rd_hi, st_rd_lo
  } xfer_e;

  typedef struct packed {
    logic [3:0] chan_power_up;
    logic [4:0] loopback_en;
    logic       cutoff_en;
    logic [3:0] tx_highway_sel;
    logic [3:0] rx_highway_sel;
    logic [3:0] mclk_sel;
    logic [6:0] tx_slot_ch1;
    logic [6:0] tx_slot_ch2;
    logic [6:0] tx_slot_ch3;
    logic [6:0] tx_slot_ch4;
    logic [2:0] clock_slope;
    logic       mu_law;
    logic [7:0] filter_sel;
  } codec_cfg_s;

  typedef struct packed {
    logic [3:0] slic_bidir_pin_a_oe;
    logic [3:0] slic_bidir_pin_b_oe;
    logic [3:0] slic_bidir_pin_c_oe;
    logic [3:0] slic_input_a_debounce;
    logic [3:0] slic_input_b_debounce;
    logic [4:0] irq_mask_n;
    logic       irq_pending;
    logic       fsk_en;
    logic [3:0] tone_en;
    logic       ring_trip_en;
    logic       level_meter_en;
    logic       chopper_out_a;
    logic       chopper_out_b;
  } codec_feat_s;
endpackage : codec_defaults_pkg

// *** hw/fsk_ram.sv ***
// shared tone-data RAM, 32 words of 16 bits, registered read data
// assumes one port and no reset on the array
module fsk_ram #(
  parameter int AW = 5,
  parameter int DW = 16
) (
  // clock
  input  wire logic          ref_clk,
  // access
  input  wire logic          wr_en,
  input  wire logic [AW-1:0] addr,
  input  wire logic [DW-1:0] wr_data,
  output      logic [DW-1:0] rd_data
);
  logic [DW-1:0] mem [0:(1<<AW)-1];

  // no reset here, contents survive any reset
  always_ff @(posedge ref_clk) begin
    if (wr_en) begin
      mem[addr] <= wr_data;
    end
    rd_data <= mem[addr];
  end
endmodule : fsk_ram

// *** tb/codec_defaults_asserts.sv ***
// checker for the default image and the identification byte of the read answer
// assumes it is bound to the codec_defaults ports
module codec_defaults_asserts #(
  parameter int         RST_PIN_CYCLES = 8,
  parameter logic [7:0] ID_BYTE        = 8'h5A
) (
  // clock and reset
  input wire logic                            ref_clk,
  input wire logic                            rstn,
  input wire logic                            reset_pin_n,
  input wire logic                            reset_cmd,
  // host byte port
  input wire logic                            cs_n,
  input wire logic                            rx_valid,
  input wire logic [7:0]                      rx_byte,
  input wire logic                            tx_ready,
  input wire logic                            tx_valid,
  input wire logic [7:0]                      tx_byte,
  input wire logic                            busy,
  // default image
  input wire logic                            in_default,
  input wire codec_defaults_pkg::codec_cfg_s  cfg,
  input wire codec_defaults_pkg::codec_feat_s feat
);
  logic [15:0] low_cnt;
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rstn);
  // consecutive cycles with the reset pin low
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) low_cnt <= 16'h0000;
    else if (reset_pin_n) low_cnt <= 16'h0000;
    else if (low_cnt != 16'hFFFF) low_cnt <= low_cnt + 16'h0001;
  end
  chop_high_a: assert property (in_default |-> feat.chopper_out_a
    && feat.chopper_out_b) else $error("chopper output not high");
  chan_idle_a: assert property (reset_cmd |=> cfg.chan_power_up == 0
    && cfg.loopback_en == 0 && !cfg.cutoff_en) else $error("channel active");
  slot_map_a: assert property (reset_cmd |=> cfg.tx_slot_ch1 == 0
    && cfg.tx_slot_ch2 == 1 && cfg.tx_slot_ch3 == 2 && cfg.tx_slot_ch4 == 3
    && cfg.tx_highway_sel == 0 && cfg.rx_highway_sel == 0)
    else $error("slot or highway default wrong");
  clock_law_a: assert property (reset_cmd |=> cfg.mclk_sel == 4'h2
    && !cfg.mu_law && cfg.filter_sel == 8'h08) else $error("clock or law");
  pins_input_a: assert property (reset_cmd |=> feat.slic_bidir_pin_a_oe == 0
    && feat.slic_bidir_pin_b_oe == 0 && feat.slic_bidir_pin_c_oe == 0
    && feat.slic_input_a_debounce == 0 && feat.slic_input_b_debounce == 0)
    else $error("signaling pin default wrong");
  irq_clear_a: assert property (reset_cmd |=> feat.irq_mask_n == 0
    && !feat.irq_pending) else $error("interrupt not cleared");
  feat_off_a: assert property (reset_cmd |=> !feat.fsk_en
    && feat.tone_en == 0 && !feat.ring_trip_en && !feat.level_meter_en)
    else $error("feature block enabled");
  read_id_a: assert property (rx_valid && !cs_n && !busy && in_default
    && rx_byte[7:3] == 5'b01110 ##1 (!cs_n && !reset_cmd && reset_pin_n)[*2]
    |-> ##[0:1] tx_valid && tx_byte == ID_BYTE) else $error("no id byte");
  tx_hold_a: assert property (tx_valid && !tx_ready && !cs_n && !reset_cmd
    && reset_pin_n |=> tx_valid && $stable(tx_byte)) else $error("tx dropped");
  pin_reset_a: assert property (low_cnt > RST_PIN_CYCLES + 1
    |-> !busy && !tx_valid) else $error("pin reset did not abort");
  cover property (rx_valid && rx_byte[7:3] == 5'b11110);
  cover property (tx_valid && tx_ready);
  cover property (low_cnt > RST_PIN_CYCLES + 1);
endmodule : codec_defaults_asserts

// *** tb/host_model.sv ***
// host side of the byte command port
// assumes tasks are entered just after a rising edge
module host_model (
  // clock
  input  wire logic       ref_clk,
  // byte port
  output      logic       cs_n,
  output      logic       rx_valid,
  output      logic [7:0] rx_byte,
  output      logic       tx_ready,
  input  wire logic       tx_valid,
  input  wire logic [7:0] tx_byte
);
  timeunit 1ns;
  timeprecision 100ps;
  bit slow = 1'b0;
  initial begin
    cs_n = 1'b0;
    rx_valid = 1'b0;
    rx_byte = 8'h00;
    tx_ready = 1'b0;
  end
  // one byte per high cycle; stays high for a following send
  task automatic send(input logic [7:0] b);
    rx_valid = 1'b1;
    rx_byte = b;
    @(posedge ref_clk);
    #1;
  endtask : send
  // released data line shows the inverse of the last byte
  task automatic quiet;
    rx_valid = 1'b0;
    rx_byte = ~rx_byte;
  endtask : quiet
  task automatic stop;
    cs_n = 1'b1;
    @(posedge ref_clk);
    #1;
    cs_n = 1'b0;
  endtask : stop
  task automatic take(output logic [7:0] b);
    int n;
    n = 0;
    quiet();
    while (tx_valid !== 1'b1 && n < 50) begin
      @(posedge ref_clk);
      #1;
      n++;
    end
    if (slow) begin
      repeat (3) @(posedge ref_clk);
      #1;
    end
    tx_ready = 1'b1;
    @(posedge ref_clk);
    b = tx_byte;
    #1;
    tx_ready = 1'b0;
  endtask : take
endmodule : host_model

// *** tb/codec_defaults_bench.sv ***
// self-checking bench for codec_defaults with a host model
// assumes host_model and the checker are compiled first
module codec_defaults_bench;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int         RP = 8;
  localparam logic [7:0] ID = 8'h5A; // arbitrary value
  logic ref_clk, rstn, reset_pin_n, reset_cmd, cs_n, rx_valid, tx_ready;
  logic tx_valid, busy, in_default;
  logic [7:0] rx_byte, tx_byte;
  codec_defaults_pkg::codec_cfg_s  cfg;
  codec_defaults_pkg::codec_feat_s feat;
  logic [15:0] mem [32];
  int num_errors = 0;
  int samples_checked = 0;
  int seed = 32'hcd16;
  codec_defaults #(.RST_PIN_CYCLES(RP), .ID_BYTE(ID)) codec_defaults_i (
    .ref_clk(ref_clk), .rstn(rstn), .reset_pin_n(reset_pin_n),
    .reset_cmd(reset_cmd), .cs_n(cs_n), .rx_valid(rx_valid),
    .rx_byte(rx_byte), .tx_ready(tx_ready), .tx_valid(tx_valid),
    .tx_byte(tx_byte), .busy(busy), .in_default(in_default), .cfg(cfg),
    .feat(feat));
  host_model host_model_i (.ref_clk(ref_clk), .cs_n(cs_n),
    .rx_valid(rx_valid), .rx_byte(rx_byte), .tx_ready(tx_ready),
    .tx_valid(tx_valid), .tx_byte(tx_byte));
  task automatic cmp(input logic [63:0] got, input logic [63:0] exp);
    samples_checked++;
    if (got !== exp) begin
      num_errors++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask : cmp
  task automatic check_defaults;
    codec_defaults_pkg::codec_cfg_s  c;
    codec_defaults_pkg::codec_feat_s f;
    c = '0;
    c.mclk_sel = 4'h2;
    c.tx_slot_ch2 = 7'h01;
    c.tx_slot_ch3 = 7'h02;
    c.tx_slot_ch4 = 7'h03;
    c.filter_sel = 8'h08;
    f = '0;
    f.chopper_out_a = 1'b1;
    f.chopper_out_b = 1'b1;
    cmp(64'(cfg), 64'(c));
    cmp(64'(feat), 64'(f));
    cmp(64'({in_default, busy}), 64'h2);
  endtask : check_defaults
  task automatic write_blk(input logic [1:0] blk, input int nb);
    logic [7:0] hi, d;
    host_model_i.send({5'b11110, 1'b0, blk});
    for (int i = 0; i < nb; i++) begin
      d = 8'($random(seed));
      host_model_i.send(d);
      if (i % 2 == 0) hi = d;
      else mem[{blk, 3'(7 - i / 2)}] = {hi, d};
    end
    host_model_i.quiet();
  endtask : write_blk
  task automatic read_blk(input logic [1:0] blk);
    logic [7:0]  d;
    logic [15:0] w;
    host_model_i.send({5'b01110, 1'b0, blk});
    host_model_i.take(d);
    cmp(64'(d), 64'(ID));
    for (int i = 0; i < 16; i++) begin
      host_model_i.take(d);
      w = mem[{blk, 3'(7 - i / 2)}];
      cmp(64'(d), 64'(i % 2 ? w[7:0] : w[15:8]));
    end
    host_model_i.stop();
  endtask : read_blk
  task automatic tally_and_finish;
    if (num_errors == 0 && samples_checked > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : tally_and_finish
  initial begin
    ref_clk = 1'b0;
    forever #4 ref_clk = ~ref_clk;
  end
  initial begin
    #100000;
    num_errors++;
    tally_and_finish();
  end
  initial begin
    rstn = 1'b0;
    reset_pin_n = 1'b1;
    reset_cmd = 1'b0;
    repeat (4) @(posedge ref_clk);
    #1 rstn = 1'b1;
    repeat (4) @(posedge ref_clk);
    #1 check_defaults();
    for (int k = 0; k < 4; k++) begin
      write_blk(k[1:0], 16);
      host_model_i.stop();
    end
    host_model_i.send(8'h68);
    host_model_i.quiet();
    for (int k = 0; k < 4; k++) begin
      host_model_i.slow = k[0];
      read_blk(k[1:0]);
    end
    // abort by chip select, reset command and reset pin
    for (int k = 0; k < 3; k++) begin
      write_blk(k[1:0], 5);
      if (k == 1) reset_cmd = 1'b1;
      if (k == 2) reset_pin_n = 1'b0;
      repeat (k == 2 ? RP + 4 : 1) @(posedge ref_clk);
      #1 reset_cmd = 1'b0;
      reset_pin_n = 1'b1;
      host_model_i.stop();
      check_defaults();
      read_blk(k[1:0]);
    end
    rstn = 1'b0;
    repeat (2) @(posedge ref_clk);
    #1 rstn = 1'b1;
    repeat (4) @(posedge ref_clk);
    #1 check_defaults();
    for (int k = 0; k < 4; k++) read_blk(k[1:0]);
    tally_and_finish();
  end
endmodule : codec_defaults_bench
bind codec_defaults codec_defaults_asserts #(
  .RST_PIN_CYCLES(RST_PIN_CYCLES), .ID_BYTE(ID_BYTE)
) asserts_i (
  .ref_clk(ref_clk), .rstn(rstn), .reset_pin_n(reset_pin_n),
  .reset_cmd(reset_cmd), .cs_n(cs_n), .rx_valid(rx_valid),
  .rx_byte(rx_byte), .tx_ready(tx_ready), .tx_valid(tx_valid),
  .tx_byte(tx_byte), .busy(busy), .in_default(in_default), .cfg(cfg),
  .feat(feat));
